// ---- include/adc_ctrl_map.svh ----
// register addresses, reset values and timing counts of the converter
`ifndef ADC_CTRL_MAP_SVH
`define ADC_CTRL_MAP_SVH
`define ADDR_PIN_FUNCTION_SELECT 16'hFF2F
`define ADDR_PORT2_DIRECTION 16'hFF22
`define ADDR_CONVERTER_MODE 16'hFF28
`define ADDR_CHANNEL_SELECT 16'hFF29
`define ADDR_RESULT_WIDE_LO 16'hFF08
`define ADDR_RESULT_WIDE_HI 16'hFF09
`define ADDR_RESULT_HIGH_BYTE 16'hFF0A
`define RST_PIN_FUNCTION_SELECT 8'h00
`define RST_PORT2_DIRECTION 8'hFF
`define RST_CONVERTER_MODE 8'h00
`define RST_CHANNEL_SELECT 8'h00
`define RST_RESULT_WIDE 16'h0000
`define RST_RESULT_HIGH_BYTE 8'h00
`define BIT_CONVERTER_ENABLE 0
`define BIT_CONVERSION_RUN 7
`define PFS_CODE_MSB 3
`define PFS_CODE_MAX 4'h8
`define CHSEL_MSB 2
`define RESULT_PAD_BITS 6
`define SAR_MSB 9
`define DEF_SAMPLE_CYCLES 24
`define DEF_BIT_CYCLES 12
`endif

// ---- include/adc_ctrl_pkg.sv ----
// types shared by the converter sequencer files
package adc_ctrl_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SAMPLE,
    ST_TRIAL,
    ST_DONE
  } seq_state_t;
  typedef logic [9:0] sar_word_t;
  typedef logic [7:0] pin_vec_t;
endpackage

// ---- core/pin_function_decode.sv ----
// per-pin analog/digital function decode of the shared port
`timescale 1ns/1ps
`include "adc_ctrl_map.svh"
module pin_function_decode (
  // settings
  input wire logic [3:0] i_pfs_code,
  input wire logic [7:0] i_direction,
  input wire logic [2:0] i_channel,
  // decoded pin functions
  output logic [7:0] o_analog,
  output logic [7:0] o_conv_target,
  output logic [7:0] o_out_buffer_en,
  output logic o_prohibited
);
  import adc_ctrl_pkg::*;
  logic [7:0] digital;
  // lowest n pins turn digital; codes above 8 leave all analog
  always_comb begin
    for (int k = 0; k < 8; k++) begin
      digital[k] = (i_pfs_code <= `PFS_CODE_MAX) &&
                   (4'(k) < i_pfs_code);
    end
  end
  // joint decode of function, direction and channel
  always_comb begin
    o_analog = ~digital;
    o_out_buffer_en = ~i_direction;
    o_conv_target = '0;
    if (!digital[i_channel] && i_direction[i_channel]) begin
      o_conv_target[i_channel] = 1'b1;
    end
    // flags what software is told never to set
    o_prohibited = (i_pfs_code > `PFS_CODE_MAX) ||
                   digital[i_channel] ||
                   |(~digital & ~i_direction);
  end
endmodule // pin_function_decode

// ---- core/sar_step.sv ----
// one trial step of the successive approximation search
`timescale 1ns/1ps
`include "adc_ctrl_map.svh"
module sar_step (
  // current search state
  input wire adc_ctrl_pkg::sar_word_t i_sar,
  input wire logic [3:0] i_bit,
  input wire logic i_cmp_high,
  // outputs
  output adc_ctrl_pkg::sar_word_t o_trial,
  output adc_ctrl_pkg::sar_word_t o_decided
);
  import adc_ctrl_pkg::*;
  // tap equals the trial word: bit set on top of the decided bits
  always_comb begin
    o_trial = i_sar;
    o_trial[i_bit] = 1'b1;
    o_decided = o_trial;
    o_decided[i_bit] = i_cmp_high; // keep if input at or above tap
  end
endmodule // sar_step

// ---- core/sar_adc_pin_config_sequencer.sv ----
// control and sequencing of the 10-bit converter and its shared pins
//
// What this block does
// - pin function select clears to zero: all pins analog after reset
// - select value n makes lowest n pins digital; above 8 prohibited
// - select register takes bit and byte writes; bits 7..4 read zero
// - select write inserts one bus wait; software avoids stopped clock
// - port 2 direction resets to all ones, every pin input
// - direction bit 0 enables output buffer, 1 disables it
// - analog input pin is converted when channel select names it
// - pin function decoded from select, direction and channel
// - sample for a fixed period, then hold until conversion ends
// - first trial sets bit 9 at half scale, keep if input at or above
// - bit 8 trial tap follows bit 9; keep when input at or above
// - same trial-and-compare continues down to bit 0
// - after ten compares load both results and pulse done request
// - next conversion starts at once until run bit cleared
// - write to mode, channel or select aborts; restarts if run set
// - reset clears wide result to 0000 and high byte to 00
// - wide result holds ten bits, high byte the upper eight
// - wide result is left-aligned, low six bits read zero
// - converter enable is mode register bit 0
// - conversion run is mode register bit 7; one starts conversion
// - clearing run stops at once, last result kept
`timescale 1ns/1ps
`include "adc_ctrl_map.svh"
module sar_adc_pin_config_sequencer #(
  parameter int CNT_W = 8
) (
  // clock, reset, enable
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  // cpu register port
  input wire logic [15:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] i_wmask,
  output logic [7:0] o_rdata,
  output logic o_wait,
  // conversion timing from the time selection
  input wire logic [CNT_W-1:0] i_sample_cycles,
  input wire logic [CNT_W-1:0] i_bit_cycles,
  // analog front end
  input wire logic i_cmp_high,
  output adc_ctrl_pkg::sar_word_t o_tap,
  output logic o_sample,
  output logic o_hold,
  output logic o_analog_on,
  // pins and events
  output logic [7:0] o_pin_analog,
  output logic [7:0] o_pin_select,
  output logic [7:0] o_pin_out_en,
  output logic o_setting_prohibited,
  output logic o_conversion_done_irq,
  output logic o_busy
);
  import adc_ctrl_pkg::*;

  // software-visible registers
  logic [7:0] pin_function_select;
  logic [7:0] port2_direction;
  logic [7:0] converter_mode_register;
  logic [7:0] channel_select;
  logic [15:0] result_wide;
  logic [7:0] result_high_byte;

  // search state and counters
  sar_word_t successive_approx_register;
  seq_state_t state;
  logic [CNT_W-1:0] cnt;
  logic [3:0] bit_idx;
  logic wait_pend;

  // decoded settings and step results
  logic converter_enable;
  logic conversion_run;
  logic [7:0] analog_w;
  logic [7:0] target_w;
  logic [7:0] out_en_w;
  logic prohibited_w;
  sar_word_t trial_w;
  sar_word_t decided_w;
  logic abort_w;
  logic sample_done;
  logic bit_done;
  logic load_result;

  // masked byte write: mask bits select the lanes touched
  function automatic logic [7:0] merge(input logic [7:0] old,
                                       input logic [7:0] wd,
                                       input logic [7:0] msk);
    merge = (old & ~msk) | (wd & msk);
  endfunction

  function automatic logic hit(input logic [15:0] addr,
                               input logic [15:0] reg_addr);
    hit = (addr == reg_addr);
  endfunction

  // last clock of a counted period; one extra bit keeps the sum from wrapping
  function automatic logic period_end(input logic [CNT_W-1:0] count,
                                      input logic [CNT_W-1:0] length);
    period_end = ({1'b0, count} + 1'b1) >= {1'b0, length};
  endfunction

  assign converter_enable = converter_mode_register[`BIT_CONVERTER_ENABLE];
  assign conversion_run = converter_mode_register[`BIT_CONVERSION_RUN];

  // a bit period lasts at least two clocks: the tap is registered, so the
  // comparator reflects the new trial word only from the second clock on
  assign sample_done = period_end(cnt, i_sample_cycles);
  assign bit_done = (cnt != '0) && period_end(cnt, i_bit_cycles);

  // a finished search loads the results unless a stop or restart wins
  assign load_result = state == ST_DONE && conversion_run && !abort_w;

  // writes to mode, channel or function select abort the search; run set restarts it
  // a write that sets run aborts too; idle then starts afresh
  assign abort_w = i_wr && !wait_pend &&
                   (hit(i_addr, `ADDR_CONVERTER_MODE) ||
                    hit(i_addr, `ADDR_CHANNEL_SELECT) ||
                    hit(i_addr, `ADDR_PIN_FUNCTION_SELECT));

  pin_function_decode u_decode (
    .i_pfs_code(pin_function_select[`PFS_CODE_MSB:0]),
    .i_direction(port2_direction),
    .i_channel(channel_select[`CHSEL_MSB:0]),
    .o_analog(analog_w),
    .o_conv_target(target_w),
    .o_out_buffer_en(out_en_w),
    .o_prohibited(prohibited_w)
  );

  sar_step u_step (
    .i_sar(successive_approx_register),
    .i_bit(bit_idx),
    .i_cmp_high(i_cmp_high),
    .o_trial(trial_w),
    .o_decided(decided_w)
  );

  // one wait state on every register write; the cpu holds i_wr through it
  // a write held into the wait cycle is ignored, never taken twice
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wait_pend <= 1'b0;
    end else if (i_ce) begin
      wait_pend <= i_wr && !wait_pend;
    end
  end

  // stall output mirrors the pending wait
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_wait <= 1'b0;
    end else if (i_ce) begin
      o_wait <= i_wr && !wait_pend;
    end
  end

  // pin function select: only the code nibble is stored
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pin_function_select <= `RST_PIN_FUNCTION_SELECT;
    end else if (i_ce && i_wr && !wait_pend &&
                 hit(i_addr, `ADDR_PIN_FUNCTION_SELECT)) begin
      pin_function_select <= merge(pin_function_select, i_wdata, i_wmask)
                             & 8'h0F;
    end
  end

  // port 2 direction
  // reset leaves every pin an input with its output buffer off
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      port2_direction <= `RST_PORT2_DIRECTION;
    end else if (i_ce && i_wr && !wait_pend &&
                 hit(i_addr, `ADDR_PORT2_DIRECTION)) begin
      port2_direction <= merge(port2_direction, i_wdata, i_wmask);
    end
  end

  // mode register holds enable, time selection bits and run
  // bits 5..1 are kept for the outside time selection only
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      converter_mode_register <= `RST_CONVERTER_MODE;
    end else if (i_ce && i_wr && !wait_pend &&
                 hit(i_addr, `ADDR_CONVERTER_MODE)) begin
      converter_mode_register <= merge(converter_mode_register, i_wdata,
                                       i_wmask);
    end
  end

  // channel select, upper bits kept at zero
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      channel_select <= `RST_CHANNEL_SELECT;
    end else if (i_ce && i_wr && !wait_pend &&
                 hit(i_addr, `ADDR_CHANNEL_SELECT)) begin
      channel_select <= merge(channel_select, i_wdata, i_wmask) & 8'h07;
    end
  end

  // conversion sequencer; run cleared or abort drops back to idle
  // idle moves to sampling on the next clock while run stays set
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state <= ST_IDLE;
      cnt <= '0;
      bit_idx <= 4'h0;
      successive_approx_register <= '0;
    end else if (i_ce) begin
      if (abort_w || !conversion_run) begin
        state <= ST_IDLE;
        cnt <= '0;
      end else begin
        case (state)
          ST_IDLE: begin
            state <= ST_SAMPLE;
            cnt <= '0;
          end
          ST_SAMPLE: begin
            // length taken from the outside time selection
            if (sample_done) begin
              state <= ST_TRIAL;
              cnt <= '0;
              // search word cleared so the first trial is bit 9 alone
              bit_idx <= 4'(`SAR_MSB);
              successive_approx_register <= '0;
            end else begin
              cnt <= cnt + 1'b1;
            end
          end
          ST_TRIAL: begin
            // comparator sampled on the last cycle of each bit period
            if (bit_done) begin
              cnt <= '0;
              successive_approx_register <= decided_w;
              if (bit_idx == 4'h0) begin
                state <= ST_DONE;
              end else begin
                bit_idx <= bit_idx - 4'h1;
              end
            end else begin
              cnt <= cnt + 1'b1;
            end
          end
          ST_DONE: begin
            // results and done request are taken from this state
            state <= ST_SAMPLE;
            cnt <= '0;
          end
          default: begin
            // unused encodings fall back to idle
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // results load only on a completed search, so a stop keeps the last one
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      result_wide <= `RST_RESULT_WIDE;
      result_high_byte <= `RST_RESULT_HIGH_BYTE;
    end else if (i_ce && load_result) begin
      result_wide <= {successive_approx_register,
                      `RESULT_PAD_BITS'(0)};
      result_high_byte <= successive_approx_register[9:2];
    end
  end

  // done request pulses in the cycle the results are loaded
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_conversion_done_irq <= 1'b0;
    end else if (i_ce) begin
      o_conversion_done_irq <= load_result;
    end
  end

  // analog front-end controls, registered
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_tap <= '0;
      o_sample <= 1'b0;
      o_hold <= 1'b0;
      o_analog_on <= 1'b0;
      o_busy <= 1'b0;
    end else if (i_ce) begin
      // tap idles at zero outside hold so the ladder rests at the bottom
      o_tap <= (state == ST_TRIAL) ? trial_w : '0;
      o_sample <= state == ST_SAMPLE;
      o_hold <= state == ST_TRIAL;
      o_analog_on <= converter_enable;
      o_busy <= state != ST_IDLE;
    end
  end

  // pin function outputs, registered one cycle after the settings
  // forbidden settings are flagged only; the decode still follows them
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_pin_analog <= 8'hFF;
      o_pin_select <= 8'h01;
      o_pin_out_en <= 8'h00;
      o_setting_prohibited <= 1'b0;
    end else if (i_ce) begin
      o_pin_analog <= analog_w;
      o_pin_select <= target_w;
      o_pin_out_en <= out_en_w;
      o_setting_prohibited <= prohibited_w;
    end
  end

  // read data registered; unmapped addresses read zero
  // result addresses are read only: no write decode matches them
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rdata <= 8'h00;
    end else if (i_ce && i_rd) begin
      case (i_addr)
        `ADDR_PIN_FUNCTION_SELECT: o_rdata <= pin_function_select;
        `ADDR_PORT2_DIRECTION: o_rdata <= port2_direction;
        `ADDR_CONVERTER_MODE: o_rdata <= converter_mode_register;
        `ADDR_CHANNEL_SELECT: o_rdata <= channel_select;
        `ADDR_RESULT_WIDE_LO: o_rdata <= result_wide[7:0];
        `ADDR_RESULT_WIDE_HI: o_rdata <= result_wide[15:8];
        `ADDR_RESULT_HIGH_BYTE: o_rdata <= result_high_byte;
        default: o_rdata <= 8'h00;
      endcase
    end
  end
endmodule // sar_adc_pin_config_sequencer

// ---- tb/adc_seq_checker.sv ----
// port-level assertions for the converter sequencer
`timescale 1ns/1ps
module adc_seq_checker #(parameter int CNT_W = 8) (
  // clock, reset and bus
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  input wire logic [15:0] i_addr,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] i_wmask,
  // observed outputs
  input wire logic o_wait,
  input wire adc_ctrl_pkg::sar_word_t o_tap,
  input wire logic o_sample,
  input wire logic o_hold,
  input wire logic [7:0] o_pin_analog,
  input wire logic [7:0] o_pin_select,
  input wire logic [7:0] o_pin_out_en,
  input wire logic o_conversion_done_irq,
  input wire logic o_busy
);
  import adc_ctrl_pkg::*;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  logic [7:0] digital;
  sar_word_t tap_lsb;
  logic wr_taken;
  // lowest set bit of the trial word is the bit under trial
  assign tap_lsb = o_tap & (~o_tap + 10'h001);
  assign digital = ~o_pin_analog;
  assign wr_taken = i_wr && i_ce && !o_wait;
  sequence run_cleared;
    wr_taken && i_addr == 16'hFF28 && i_wmask[7] && !i_wdata[7];
  endsequence
  sequence trial_advance;
    o_hold && $past(o_hold) && $changed(o_tap);
  endsequence
  a_write_wait: assert property (
    wr_taken |=> o_wait)
    else $error("no wait cycle after write");
  a_digital_low: assert property (
    (digital & (digital + 8'h01)) == 8'h00)
    else $error("digital pins not the lowest ones");
  a_target_analog: assert property (
    $onehot0(o_pin_select) &&
    (o_pin_select & (digital | o_pin_out_en)) == 8'h00)
    else $error("conversion target not an analog input");
  a_hold_after_sample: assert property (
    $rose(o_hold) |-> $past(o_sample))
    else $error("hold without sampling first");
  a_first_trial: assert property (
    $rose(o_hold) |-> o_tap == 10'h200)
    else $error("first trial is not bit 9 at half scale");
  a_trial_step: assert property (
    trial_advance |-> (tap_lsb << 1) == $past(tap_lsb))
    else $error("trial did not move one bit down");
  a_done_after_hold: assert property (
    o_conversion_done_irq |-> $past(o_hold) || $past(o_hold, 2))
    else $error("done request without a finished search");
  a_done_single: assert property (
    o_conversion_done_irq && i_ce |=> !o_conversion_done_irq)
    else $error("done request longer than one cycle");
  a_next_start: assert property (
    o_conversion_done_irq |-> ##[0:2] o_sample)
    else $error("next conversion did not start");
  a_run_stop: assert property (
    run_cleared |-> ##[1:3] !o_busy)
    else $error("clearing run did not stop conversion");
endmodule // adc_seq_checker
bind sar_adc_pin_config_sequencer adc_seq_checker #(.CNT_W(CNT_W)) chk_i (
  .i_clk, .i_rst_b, .i_ce, .i_addr, .i_wr, .i_wdata, .i_wmask, .o_wait,
  .o_tap, .o_sample, .o_hold, .o_pin_analog, .o_pin_select, .o_pin_out_en,
  .o_conversion_done_irq, .o_busy);

// ---- tb/analog_front_model.sv ----
// sample-and-hold and comparator facing the converter
`timescale 1ns/1ps
module analog_front_model (
  // converter side
  input wire logic i_clk,
  input wire logic i_sample,
  input wire logic i_hold,
  input wire adc_ctrl_pkg::sar_word_t i_tap,
  // pin level as a code
  input wire adc_ctrl_pkg::sar_word_t i_level,
  // decision
  output logic o_cmp_high
);
  import adc_ctrl_pkg::*;
  sar_word_t held = 10'h000;
  logic junk = 1'b0;
  // capture while sampling; later pin changes must not leak in
  always @(posedge i_clk) begin
    if (i_sample) held <= i_level;
    junk <= ~junk;
  end
  // meaningless outside hold, so it toggles instead of standing still
  assign o_cmp_high = i_hold ? (held >= i_tap) : junk;
endmodule // analog_front_model

// ---- tb/sar_adc_pin_config_sequencer_tb.sv ----
// register-level bench for the converter sequencer
`timescale 1ns/1ps
module sar_adc_pin_config_sequencer_tb;
  import adc_ctrl_pkg::*;
  localparam int S = 4;
  localparam int B = 2;
  localparam int CONV = S + 10 * B; // sample plus ten bit periods
  logic i_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_ce = 1'b1;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [15:0] i_addr = 16'h0000;
  logic [7:0] i_wdata = 8'h00;
  logic [7:0] i_wmask = 8'hFF;
  logic [7:0] o_rdata, o_pin_analog, o_pin_select, o_pin_out_en, e;
  logic o_wait, o_sample, o_hold, o_analog_on, o_setting_prohibited;
  logic o_conversion_done_irq, o_busy, cmp;
  sar_word_t o_tap;
  sar_word_t level = 10'h2B5;
  sar_word_t lv[5] = '{10'h2B5, 10'h3FF, 10'h000, 10'h200, 10'h1FF};
  int fails = 0;
  int compares = 0;
  int n;
  always #2.5 i_clk = ~i_clk;
  sar_adc_pin_config_sequencer uut (.i_clk, .i_rst_b, .i_ce,
    .i_addr, .i_wr, .i_rd, .i_wdata, .i_wmask, .o_rdata, .o_wait,
    .i_sample_cycles(8'(S)), .i_bit_cycles(8'(B)), .i_cmp_high(cmp),
    .o_tap, .o_sample, .o_hold, .o_analog_on, .o_pin_analog,
    .o_pin_select, .o_pin_out_en, .o_setting_prohibited,
    .o_conversion_done_irq, .o_busy);
  analog_front_model afe (.i_clk, .i_sample(o_sample), .i_hold(o_hold),
    .i_tap(o_tap), .i_level(level), .o_cmp_high(cmp));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // cpu holds the write through its wait cycle
  task automatic wr(input logic [15:0] a, input logic [7:0] d,
    input logic [7:0] m = 8'hFF);
    @(posedge i_clk) #1;
    i_addr = a;
    i_wdata = d;
    i_wmask = m;
    i_wr = 1'b1;
    @(posedge i_clk) #1;
    chk(o_wait, 1'b1);
    @(posedge i_clk) #1;
    i_wr = 1'b0;
  endtask
  task automatic rchk(input logic [15:0] a, input logic [7:0] exp);
    @(posedge i_clk) #1;
    i_addr = a;
    i_rd = 1'b1;
    @(posedge i_clk) #1;
    i_rd = 1'b0;
    chk(o_rdata, exp);
  endtask
  // bounded wait for the next done pulse, returns cycles taken
  task automatic wait_irq(output int cyc);
    cyc = 0;
    do begin
      @(posedge i_clk) #1;
      cyc++;
    end while (o_conversion_done_irq !== 1'b1 && cyc < 400);
    if (cyc >= 400) fails++;
  endtask
  task automatic results;
    if (fails == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // watchdog at 10000 cycles, about twelve times the roughly 800 cycles the tests need
  initial begin
    #50000;
    fails++;
    results();
  end
  initial begin
    repeat (4) @(posedge i_clk);
    #1 i_rst_b = 1'b1;
    chk(o_pin_analog, 8'hFF);
    chk(o_pin_out_en, 8'h00);
    rchk(16'hFF2F, 8'h00);
    rchk(16'hFF22, 8'hFF);
    rchk(16'hFF08, 8'h00);
    rchk(16'hFF09, 8'h00);
    rchk(16'hFF0A, 8'h00);
    rchk(16'hFF00, 8'h00);
    for (n = 0; n <= 8; n++) begin
      wr(16'hFF2F, 8'(n));
      e = 8'hFF << n;
      chk(o_pin_analog, e);
    end
    wr(16'hFF2F, 8'h09);
    chk(o_setting_prohibited, 1'b1);
    wr(16'hFF2F, 8'hF3);
    rchk(16'hFF2F, 8'h03);
    wr(16'hFF2F, 8'hFF, 8'h08);
    rchk(16'hFF2F, 8'h0B);
    wr(16'hFF2F, 8'h00);
    wr(16'hFF22, 8'h5A);
    chk(o_pin_out_en, 8'hA5);
    chk(o_setting_prohibited, 1'b1);
    rchk(16'hFF22, 8'h5A);
    wr(16'hFF22, 8'hFF);
    wr(16'hFF29, 8'h03);
    chk(o_pin_select, 8'h08);
    chk(o_setting_prohibited, 1'b0);
    wr(16'hFF2F, 8'h04);
    chk(o_pin_select, 8'h00);
    chk(o_setting_prohibited, 1'b1);
    wr(16'hFF2F, 8'h00);
    wr(16'hFF28, 8'h01);
    chk(o_analog_on, 1'b1);
    repeat (200) @(posedge i_clk);
    wr(16'hFF28, 8'h81);
    rchk(16'hFF28, 8'h81);
    // boundary levels; the second pulse is a whole conversion
    foreach (lv[i]) begin
      level = lv[i];
      wait_irq(n);
      wait_irq(n);
      chk(16'(n >= CONV && n <= CONV + 3), 16'h0001);
      rchk(16'hFF09, level[9:2]);
      rchk(16'hFF08, {level[1:0], 6'h00});
      rchk(16'hFF0A, level[9:2]);
    end
    wait_irq(n);
    repeat (10) @(posedge i_clk);
    wr(16'hFF29, 8'h03);
    wait_irq(n);
    chk(16'(n >= CONV), 16'h0001);
    repeat (8) @(posedge i_clk);
    wr(16'hFF28, 8'h01);
    chk(o_busy, 1'b0);
    n = 0;
    repeat (100) begin
      @(posedge i_clk) #1;
      if (o_conversion_done_irq === 1'b1) n++;
    end
    chk(16'(n), 16'h0000);
    rchk(16'hFF0A, level[9:2]);
    wr(16'hFF28, 8'h81);
    wait_irq(n);
    chk(16'(n <= CONV + 6), 16'h0001);
    // a frozen clock enable stretches the running conversion
    @(posedge i_clk) #1;
    i_ce = 1'b0;
    repeat (10) @(posedge i_clk);
    #1 i_ce = 1'b1;
    wait_irq(n);
    chk(16'(n >= CONV && n <= CONV + 3), 16'h0001);
    results();
  end
endmodule // sar_adc_pin_config_sequencer_tb
